//--- rtl/sac_pkg.sv
package sac_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_CHREF = 8'h08;
  localparam logic [7:0] OFS_RES_LO = 8'h0C;
  localparam logic [7:0] OFS_RES_HI = 8'h10;

  // converter_control_status_a fields
  localparam int BIT_ENABLE = 7;
  localparam int BIT_START = 6;
  localparam int BIT_AUTO = 5;
  localparam int BIT_FLAG = 4;
  localparam int POS_PRESC = 0;
  // channel_reference_select_reg fields
  localparam int POS_REF = 6;
  localparam int BIT_LEFT = 5;
  localparam int POS_CHAN = 0;

  // reset values
  localparam logic [7:0] RST_CTRL_A = 8'h00;
  localparam logic [2:0] RST_TRIG_SEL = 3'h0;
  localparam logic [7:0] RST_CHREF = 8'h00;

  // trigger select code meaning "own complete flag"
  localparam logic [2:0] TRIG_FREE_RUN = 3'h0;

  // conversion lengths in converter clock ticks
  localparam logic [4:0] CONV_NORMAL = 5'h0D;
  localparam logic [4:0] CONV_FIRST = 5'h19;
  // ticks of sampling at start of a conversion
  localparam logic [4:0] SAMPLE_NORMAL = 5'h02;
  localparam logic [4:0] SAMPLE_FIRST = 5'h0E;
  localparam int RES_BITS = 10;

  // single-ended special channels
  localparam logic [4:0] CHAN_BANDGAP = 5'h1E;
  localparam logic [4:0] CHAN_GROUND = 5'h1F;

  // gain codes for the differential stage
  localparam logic [1:0] GAIN_1X = 2'h0;
  localparam logic [1:0] GAIN_10X = 2'h1;
  localparam logic [1:0] GAIN_200X = 2'h2;

  // control bundle towards the analog core
  typedef struct packed {
    logic enable;
    logic [1:0] reference;
    logic [4:0] channel;
    logic gainBypass;
    logic [1:0] gain;
    logic sampleHold;
    logic [RES_BITS-1:0] dacCode;
  } sac_ana_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_CONV = 3'b100
  } sac_state_t;

endpackage

//--- rtl/sac_sync.sv
`timescale 1ns/100ps
module sac_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // asynchronous level in, synchronised level out
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  logic [W-1:0] meta_q;

  // two stages; the first is read only by the second
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      syncOut <= '0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule

//--- rtl/sac_prescaler.sv
`timescale 1ns/100ps
module sac_prescaler
  import sac_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // hold in reset, ratio select
  input wire logic clear,
  input wire logic [2:0] ratioSel,
  // one-cycle pulse per converter clock rising edge
  output logic tick
);

  logic [6:0] count_q;
  logic [6:0] last;

  // ratio 2 for codes 0 and 1, else two to the code
  always_comb begin
    last = (ratioSel == 3'h0) ? 7'h01 : 7'((8'h01 << ratioSel) - 8'h01);
  end

  // counter restarts on clear so a trigger gives a fixed delay
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 7'h00;
      tick <= 1'b0;
    end else if (clear) begin
      count_q <= 7'h00;
      tick <= 1'b0;
    end else if (count_q >= last) begin
      count_q <= 7'h00;
      tick <= 1'b1;
    end else begin
      count_q <= count_q + 7'h01;
      tick <= 1'b0;
    end
  end

endmodule

//--- rtl/sac_conv_ctrl.sv
`timescale 1ns/100ps
// What this block does
// [RL1] result is 10 bits over two bytes, right aligned unless left align set
// [RL2] low byte read blocks result updates until high byte is read
// [RL3] software reads low byte before high byte, or high byte alone if left aligned
// [RL4] complete flag still sets when a blocked result is discarded
// [RL5] writing start bit begins one conversion; bit clears at completion
// [RL6] channel change during a conversion applies after it completes
// [RL7] reference and channel selections act only while converter enabled
// [RL8] auto trigger rising edge resets prescaler and starts a conversion
// [RL9] trigger edges during conversion ignored; high level at end starts nothing
// [RL10] software clears a peripheral flag trigger before next event starts conversion
// [RL11] own complete flag as trigger restarts after each conversion; first by start bit
// [RL12] start bit works in auto mode and reads one during any conversion
// [RL13] converter clock from prescaler by select field, counts once enabled
// [RL14] software picks prescaler giving 50 to 200 kHz for full resolution
// [RL15] channel field picks single-ended input or differential pair with gain
// [RL16] single-ended channels bypass the gain amplifier
// [RL17] reference bits choose supply, internal 2.56V or 1.1V source
// [RL18] code zero is ground, all ones is reference minus one step
// [RL19] software disables converter before sleep to save power
// [RL20] conversion takes 13 ticks, first after enable takes 25
// [RL21] prescaler runs while enabled, held in reset while disabled
// [RL22] completion writes result, sets flag, clears start bit in single mode
// [RL23] start-bit conversion begins at next converter clock rising edge
// [RL24] prescaler offers power-of-two ratios from the select field
// [RL25] trigger edges found by comparing current and previous samples
module sac_conv_ctrl
  import sac_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // on-chip trigger sources, same clock; bit 0 unused
  input wire logic [7:0] trigIn,
  // analog core
  input wire logic compIn,
  output sac_ana_t anaCtrl,
  // completion pulse for the interrupt controller
  output logic convDone
);

  // software registers
  logic enable_q;
  logic auto_q;
  logic flag_q;
  logic [2:0] presc_q;
  logic [2:0] trigSel_q;
  logic [7:0] chref_q;
  logic [RES_BITS-1:0] result_q;
  logic lock_q;
  // sequencing
  sac_state_t state_q;
  logic [4:0] cnt_q;
  logic [3:0] bitIdx_q;
  logic firstPend_q;
  logic isFirst_q;
  logic trigPrev_q;
  logic [RES_BITS-1:0] sar_q;

  logic access;
  logic wrEn;
  logic rdEn;
  logic mapped;
  logic tick;
  logic compHigh;
  logic [4:0] total;
  logic [4:0] sampleLen;
  logic lastTick;
  logic done;
  logic freeRun;
  logic trigCur;
  logic trigEdge;
  logic swStart;
  logic startReq;
  logic leftAlign;
  logic [7:0] resLo;
  logic [7:0] resHi;
  logic [7:0] ctrlA;
  logic [4:0] chan;

  // bus decode; writes and reads act where pready is sampled high
  assign access = psel && penable;
  assign wrEn = access && pready && pwrite;
  assign rdEn = access && pready && !pwrite;
  assign mapped = (paddr == OFS_CTRL_A) || (paddr == OFS_CTRL_B) || (paddr == OFS_CHREF) ||
                  (paddr == OFS_RES_LO) || (paddr == OFS_RES_HI);

  // comparator comes from the analog core, not this clock
  sac_sync #(.W(1)) uCompSync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .asyncIn(compIn),
    .syncOut(compHigh)
  );

  // trigger edge also clears the prescaler for a fixed start delay
  sac_prescaler uPresc (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clear(!enable_q || trigEdge), // [RL21] [RL8]
    .ratioSel(presc_q), // [RL24]
    .tick(tick) // [RL13]
  );

  // conversion length and timing points
  assign total = isFirst_q ? CONV_FIRST : CONV_NORMAL; // [RL20]
  assign sampleLen = isFirst_q ? SAMPLE_FIRST : SAMPLE_NORMAL;
  assign lastTick = (state_q == ST_CONV) && (cnt_q == total - 5'h01);
  assign done = tick && lastTick && enable_q; // a disable in the last cycle aborts too
  assign freeRun = auto_q && (trigSel_q == TRIG_FREE_RUN);

  // edge detection on the selected on-chip source
  assign trigCur = (trigSel_q == TRIG_FREE_RUN) ? 1'b0 : trigIn[trigSel_q];
  assign trigEdge = enable_q && auto_q && trigCur && !trigPrev_q &&
                    (state_q == ST_IDLE); // [RL25] [RL9] [RL10]

  // start bit write launches a conversion in either mode
  assign swStart = wrEn && (paddr == OFS_CTRL_A) && pwdata[BIT_START] &&
                   pwdata[BIT_ENABLE] && (state_q == ST_IDLE); // [RL5] [RL12] [RL11]
  assign startReq = swStart || trigEdge;

  // result presentation
  assign leftAlign = chref_q[BIT_LEFT];
  assign resLo = leftAlign ? {result_q[1:0], 6'h00} : result_q[7:0]; // [RL1]
  assign resHi = leftAlign ? result_q[9:2] : {6'h00, result_q[9:8]}; // [RL1]
  assign ctrlA = {enable_q, (state_q != ST_IDLE), auto_q, flag_q, 1'b0, presc_q}; // [RL12]
  assign chan = chref_q[POS_CHAN +: 5];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      trigPrev_q <= 1'b0;
    end else begin
      trigPrev_q <= trigCur; // [RL25]
    end
  end

  // apb handshake: one wait state so read data comes from a register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (access && !pready) begin
      pready <= 1'b1;
      pslverr <= !mapped;
      unique case (paddr)
        OFS_CTRL_A: prdata <= {24'h00_0000, ctrlA};
        OFS_CTRL_B: prdata <= {29'h0000_0000, trigSel_q};
        OFS_CHREF: prdata <= {24'h00_0000, chref_q};
        OFS_RES_LO: prdata <= {24'h00_0000, resLo};
        OFS_RES_HI: prdata <= {24'h00_0000, resHi};
        default: prdata <= 32'h0000_0000;
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // control and select registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_q <= RST_CTRL_A[BIT_ENABLE];
      auto_q <= RST_CTRL_A[BIT_AUTO];
      presc_q <= RST_CTRL_A[POS_PRESC +: 3];
      trigSel_q <= RST_TRIG_SEL;
      chref_q <= RST_CHREF;
    end else if (wrEn) begin
      unique case (paddr)
        OFS_CTRL_A: begin
          enable_q <= pwdata[BIT_ENABLE];
          auto_q <= pwdata[BIT_AUTO];
          presc_q <= pwdata[POS_PRESC +: 3];
        end
        OFS_CTRL_B: trigSel_q <= pwdata[2:0];
        OFS_CHREF: chref_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // complete flag: write one clears, a completion in the same cycle wins
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_q <= RST_CTRL_A[BIT_FLAG];
    end else if (done) begin
      flag_q <= 1'b1; // [RL4] [RL22]
    end else if (wrEn && (paddr == OFS_CTRL_A) && pwdata[BIT_FLAG]) begin
      flag_q <= 1'b0;
    end
  end

  // result pair lock between the low and high byte reads
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_q <= 1'b0;
    end else if (rdEn && (paddr == OFS_RES_LO)) begin
      lock_q <= 1'b1; // [RL2] [RL3]
    end else if (rdEn && (paddr == OFS_RES_HI)) begin
      lock_q <= 1'b0; // [RL2]
    end
  end

  // result register; a completion while locked is dropped
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      result_q <= '0;
    end else if (done && !lock_q) begin
      result_q <= sar_q; // [RL22] [RL2]
    end
  end

  // first conversion after enable gets the long initialisation
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      firstPend_q <= 1'b0;
    end else if (!enable_q) begin
      firstPend_q <= 1'b1;
    end else if (state_q == ST_WAIT && tick) begin
      firstPend_q <= 1'b0;
    end
  end

  // conversion sequencer; disabling aborts everything
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 5'h00;
      isFirst_q <= 1'b0;
    end else if (!enable_q && !swStart) begin // a start that also enables is kept
      state_q <= ST_IDLE;
      cnt_q <= 5'h00;
      isFirst_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (startReq) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (tick) begin
            state_q <= ST_CONV; // [RL23]
            cnt_q <= 5'h00;
            isFirst_q <= firstPend_q; // [RL20]
          end
        end
        ST_CONV: begin
          if (done) begin
            // single mode drops back to idle, clearing the start bit
            state_q <= freeRun ? ST_WAIT : ST_IDLE; // [RL11] [RL22] [RL5] [RL9]
            cnt_q <= 5'h00;
          end else if (tick) begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // the comparator answers four core cycles after a trial is set, so ratios
  // below four decide on a stale trial; only reduced resolution there
  // successive approximation: one bit decided per tick after sampling
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sar_q <= '0;
      bitIdx_q <= 4'h9;
    end else if (state_q == ST_WAIT && tick) begin
      sar_q <= 10'h200;
      bitIdx_q <= 4'h9;
    end else if (state_q == ST_CONV && tick && cnt_q >= sampleLen && !lastTick) begin
      // code zero at ground; input above trial keeps the bit
      sar_q[bitIdx_q] <= compHigh; // [RL18]
      if (bitIdx_q != 4'h0) begin
        sar_q[bitIdx_q - 4'h1] <= 1'b1;
        bitIdx_q <= bitIdx_q - 4'h1;
      end
    end
  end

  // analog controls; selections follow software only while enabled
  // and freeze during a conversion except its last tick
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      anaCtrl <= '0;
      convDone <= 1'b0;
    end else begin
      anaCtrl.enable <= enable_q;
      anaCtrl.dacCode <= sar_q;
      anaCtrl.sampleHold <= (state_q == ST_CONV) && (cnt_q < sampleLen);
      convDone <= done;
      if (enable_q && (state_q != ST_CONV || lastTick)) begin // [RL7] [RL6]
        anaCtrl.reference <= chref_q[POS_REF +: 2]; // [RL17]
        anaCtrl.channel <= chan; // [RL15]
        anaCtrl.gainBypass <= (chan[4:3] != 2'b01) || (chan == CHAN_BANDGAP) ||
                              (chan == CHAN_GROUND); // [RL16]
        anaCtrl.gain <= (chan[4:3] != 2'b01) ? GAIN_1X :
                        (chan[1] ? GAIN_200X : GAIN_10X); // [RL15]
      end
    end
  end

endmodule

//--- testbench/sac_ana_model.sv
`timescale 1ns/100ps
module sac_ana_model
  import sac_pkg::*;
(
  // controls from the converter
  input wire sac_ana_t anaCtrl,
  // comparator decision
  output logic compIn
);
  logic [9:0] level;
  // ground is code zero, every other input a level unique to its channel
  assign level = (anaCtrl.channel == CHAN_GROUND) ? 10'h000 : {anaCtrl.channel, 5'h15};
  // unpowered core has no steady answer, so it wobbles with the trial code
  assign compIn = anaCtrl.enable ? (level >= anaCtrl.dacCode) : ~anaCtrl.dacCode[0];
endmodule

//--- testbench/sac_checker.sv
`timescale 1ns/100ps
module sac_checker
  import sac_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // triggers and analog core
  input wire logic [7:0] trigIn,
  input wire logic compIn,
  input wire sac_ana_t anaCtrl,
  input wire logic convDone
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic mapped;
  logic isDiff;
  // decoded views shared by several checks
  assign mapped = paddr inside {OFS_CTRL_A, OFS_CTRL_B, OFS_CHREF, OFS_RES_LO, OFS_RES_HI};
  assign isDiff = anaCtrl.channel[4:3] == 2'h1;
  // apb access steps
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_oneWait;
    !pready ##1 pready;
  endsequence
  a_ready_wait: assert property (s_setup |=> s_oneWait)
    else $error("pready not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  a_done_pulse: assert property (convDone |=> !convDone)
    else $error("completion pulse too long");
  a_bypass_se: assert property (
    anaCtrl.enable && $stable(anaCtrl.channel) |-> anaCtrl.gainBypass == !isDiff)
    else $error("gain bypass wrong for channel");
  a_gain_pick: assert property (
    anaCtrl.enable && isDiff && $stable(anaCtrl.channel)
    |-> anaCtrl.gain == (anaCtrl.channel[1] ? GAIN_200X : GAIN_10X))
    else $error("gain code wrong for channel");
  // selections must hold while the sample is taken
  a_chan_held: assert property (
    $rose(anaCtrl.sampleHold) |=> ($stable(anaCtrl.channel) && $stable(anaCtrl.reference)) [*8])
    else $error("selection moved during conversion");
  a_off_quiet: assert property (
    !anaCtrl.enable && !$past(anaCtrl.enable) |-> !anaCtrl.sampleHold && !convDone)
    else $error("activity while disabled");
endmodule

bind sac_conv_ctrl sac_checker chk_u (.core_clk, .reset_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .trigIn, .compIn, .anaCtrl, .convDone);

//--- testbench/testbench.sv
`timescale 1ns/100ps
module testbench
  import sac_pkg::*;
;
  logic core_clk = 1'h0;
  logic reset_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] trigIn = 8'h00;
  logic [31:0] prdata;
  logic pready, pslverr, compIn, convDone, err;
  sac_ana_t anaCtrl;
  logic [31:0] rd;
  int fails = 0;
  int checks_done = 0;
  int c;

  // 50 MHz core clock
  always #10 core_clk = ~core_clk;

  sac_conv_ctrl dut (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .trigIn, .compIn, .anaCtrl, .convDone);
  sac_ana_model ana (.anaCtrl, .compIn);

  task automatic test_done();
    if (fails == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic rng(input int v, input int lo, input int hi);
    chk(32'(v >= lo && v <= hi), 32'h1);
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'h1;
    do begin
      @(posedge core_clk);
      n++;
      if (n > 20) begin
        fails++;
        test_done();
      end
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    apb(1'h0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask

  // cycles until the completion pulse, bounded
  task automatic wait_done(output int k);
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
      if (k > 4000) begin
        fails++;
        test_done();
      end
    end while (convDone !== 1'h1);
  endtask

  task automatic count_done(input int cyc, output int k);
    k = 0;
    repeat (cyc) begin
      @(posedge core_clk);
      if (convDone === 1'h1) k++;
    end
  endtask

  task automatic t_reset();
    rdc(OFS_CTRL_A, RST_CTRL_A);
    rdc(OFS_CTRL_B, {5'h00, RST_TRIG_SEL});
    rdc(OFS_CHREF, RST_CHREF);
    apb(1'h0, 8'h14, 8'h00);
    chk(32'(err), 32'h1);
  endtask

  // bandgap right aligned, first and normal timing; /4 is the fastest
  // ratio whose result is exact, the comparator path being four cycles long
  task automatic t_single();
    wr(OFS_CHREF, 8'h1E);
    wr(OFS_CTRL_A, 8'h82);
    wr(OFS_CTRL_A, 8'hC2);
    wait_done(c);
    rng(c, 102, 105);
    rdc(OFS_CTRL_A, 8'h92);
    rdc(OFS_RES_LO, 8'hD5);
    rdc(OFS_RES_HI, 8'h03);
    wr(OFS_CTRL_A, 8'hD2);
    wait_done(c);
    rng(c, 54, 57);
    wr(OFS_CTRL_A, 8'hD3);
    rdc(OFS_CTRL_A, 8'hC3);
    wait_done(c);
    rng(c, 96, 115);
  endtask

  // left aligned lock, then channel change mid-conversion
  task automatic t_lock();
    wr(OFS_CHREF, 8'h23);
    wr(OFS_CTRL_A, 8'hD2);
    wait_done(c);
    rdc(OFS_RES_LO, 8'h40);
    wr(OFS_CHREF, 8'h24);
    wr(OFS_CTRL_A, 8'hD2);
    wait_done(c);
    rdc(OFS_CTRL_A, 8'h92);
    rdc(OFS_RES_HI, 8'h1D);
    wr(OFS_CTRL_A, 8'hD2);
    wr(OFS_CHREF, 8'h27);
    wait_done(c);
    rdc(OFS_RES_HI, 8'h25);
    wr(OFS_CTRL_A, 8'hD2);
    wait_done(c);
    rdc(OFS_RES_HI, 8'h3D);
  endtask

  // expected bypass and gain as {bypass, gain} per channel
  task automatic t_sel();
    logic [4:0] chs [4] = '{5'h05, 5'h09, 5'h0B, 5'h1F};
    logic [2:0] gns [4] = '{3'h4, 3'h1, 3'h2, 3'h4};
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CHREF, {i[1:0], 1'h0, chs[i]});
      repeat (3) @(posedge core_clk);
      chk(32'(anaCtrl.reference), 32'(i));
      chk(32'(anaCtrl.channel), 32'(chs[i]));
      chk(32'({anaCtrl.gainBypass, anaCtrl.gain}), 32'(gns[i]));
    end
  endtask

  // selections and starts are dead while disabled; enable and start together
  task automatic t_gate();
    wr(OFS_CTRL_A, 8'h00);
    wr(OFS_CHREF, 8'h0C);
    repeat (3) @(posedge core_clk);
    chk(32'(anaCtrl.channel == 5'h0C), 32'h0);
    wr(OFS_CTRL_A, 8'h40);
    count_done(80, c);
    chk(32'(c), 32'h0);
    wr(OFS_CTRL_A, 8'hC2);
    wait_done(c);
    rng(c, 102, 106);
    chk(32'(anaCtrl.channel), 32'h0C);
  endtask

  // trigger dropped and raised again during the conversion is ignored; one completion only
  task automatic t_auto();
    wr(OFS_CTRL_B, 8'h02);
    wr(OFS_CTRL_A, 8'hB1);
    trigIn <= 8'h04;
    rdc(OFS_CTRL_A, 8'hE1);
    trigIn <= 8'h00;
    @(posedge core_clk);
    trigIn <= 8'h04;
    count_done(200, c);
    chk(32'(c), 32'h1);
    trigIn <= 8'h00;
  endtask

  // free running on own completion, flag cleared only by the starting write
  task automatic t_free();
    wr(OFS_CTRL_B, 8'h00);
    wr(OFS_CTRL_A, 8'hF1);
    count_done(300, c);
    rng(c, 9, 12);
    rdc(OFS_CTRL_A, 8'hF1);
    wr(OFS_CTRL_A, 8'h00);
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    reset_n <= 1'h1;
    t_reset();
    t_single();
    t_lock();
    t_sel();
    t_gate();
    t_auto();
    t_free();
    test_done();
  end
endmodule
